/* File: rtl/crc_pkg.sv */
// Package of constants for the checksum generator.
// Assumes a single 50 MHz clock and a plain strobe register port.
`default_nettype none
package crc_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [3:0] CRC_OFF_CTRL = 4'h0;
  localparam logic [3:0] CRC_OFF_SEED = 4'h4;
  localparam logic [3:0] CRC_OFF_DATA = 4'h8;
  localparam logic [3:0] CRC_OFF_SUM = 4'hC;

  // ****************************************
  // Control fields
  // ****************************************
  localparam int CRC_CTRL_START = 0;
  localparam int CRC_CTRL_DREV = 1;
  localparam int CRC_CTRL_SREV = 2;
  localparam int CRC_CTRL_DINV = 3;
  localparam int CRC_CTRL_SINV = 4;
  localparam int CRC_CTRL_BUSY = 5;
  localparam int CRC_CTRL_WID_LO = 8;
  localparam int CRC_CTRL_POLY_LO = 12;
  localparam logic [31:0] CRC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CRC_SEED_RST = 32'hFFFF_FFFF;
  // Engine cycles left after the write edge
  localparam logic [1:0] CRC_LEFT_16 = 2'h1;
  localparam logic [1:0] CRC_LEFT_32 = 2'h3;

  // ****************************************
  // Polynomials and modes
  // ****************************************
  localparam logic [31:0] CRC_POLY_CCITT = 32'h0000_1021;
  localparam logic [31:0] CRC_POLY_8 = 32'h0000_0007;
  localparam logic [31:0] CRC_POLY_16 = 32'h0000_8005;
  localparam logic [31:0] CRC_POLY_32 = 32'h04C1_1DB7;

  typedef enum logic [1:0] {
    CRC_SEL_CCITT = 2'h0,
    CRC_SEL_8 = 2'h1,
    CRC_SEL_16 = 2'h2,
    CRC_SEL_32 = 2'h3
  } crc_sel_t;

  typedef enum logic [1:0] {
    CRC_WID_8 = 2'h0,
    CRC_WID_16 = 2'h1,
    CRC_WID_32 = 2'h2
  } crc_wid_t;

  typedef enum logic [1:0] {
    CRC_ST_IDLE = 2'h0,
    CRC_ST_RUN = 2'h1
  } crc_state_t;

endpackage
`default_nettype wire

/* File: rtl/crc_byte_step.sv */
// One byte step of a CRC of selectable width, MSB first.
// Assumes the running value is held right-aligned in the low bits.
`timescale 1ns/1ps
`default_nettype none
module crc_byte_step (
  // Current value and operand
  input wire logic [31:0] crc_in,
  input wire logic [7:0] byte_in,
  input wire logic [1:0] sel_in,
  // Next value
  output logic [31:0] crc_out
);

  logic [31:0] poly;
  logic [31:0] topm;
  logic [31:0] c;
  logic fb;

  always_comb begin
    poly = crc_pkg::CRC_POLY_32;
    topm = 32'h8000_0000;
    case (sel_in)
      crc_pkg::CRC_SEL_CCITT: begin
        poly = crc_pkg::CRC_POLY_CCITT;
        topm = 32'h0000_8000;
      end
      crc_pkg::CRC_SEL_8: begin
        poly = crc_pkg::CRC_POLY_8;
        topm = 32'h0000_0080;
      end
      crc_pkg::CRC_SEL_16: begin
        poly = crc_pkg::CRC_POLY_16;
        topm = 32'h0000_8000;
      end
      default: begin
        poly = crc_pkg::CRC_POLY_32;
        topm = 32'h8000_0000;
      end
    endcase
    c = crc_in;
    for (int i = 7; i >= 0; i--) begin
      fb = (|(c & topm)) ^ byte_in[i];
      c = c << 1;
      if (fb) begin
        c = c ^ poly;
      end
    end
    // Mask to the active width
    crc_out = c & ((topm << 1) - 32'h0000_0001);
  end

endmodule // crc_byte_step
`default_nettype wire

/* File: rtl/crc_gen.sv */
// Checksum generator with a strobe register port.
// Assumes software or the DMA channel share the same port; busy makes
// the port stall via data_ready_out.
`timescale 1ns/1ps
`default_nettype none
module crc_gen (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  // Register port
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // Flow control towards the writer
  output logic data_ready_out
);

  // ****************************************
  // State
  // ****************************************
  logic [31:0] ctrl_ff;
  logic [31:0] nxt_ctrl;
  logic [31:0] seed_ff;
  logic [31:0] nxt_seed;
  logic [31:0] crc_ff;
  logic [31:0] nxt_crc;
  logic [31:0] shreg_ff;
  logic [31:0] nxt_shreg;
  logic [1:0] left_ff;
  logic [1:0] nxt_left;
  crc_pkg::crc_state_t state_ff;
  crc_pkg::crc_state_t nxt_state;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  logic [1:0] sel;
  logic [1:0] wid;
  logic [31:0] din;
  logic [31:0] din_rev;
  logic [31:0] sum_masked;
  logic [31:0] sum_rev;
  logic [31:0] sum_view;
  logic [31:0] width_mask;
  logic [31:0] step_out;
  logic [7:0] step_byte;
  logic data_wr;
  logic start_wr;

  assign sel = ctrl_ff[crc_pkg::CRC_CTRL_POLY_LO +: 2];
  assign wid = ctrl_ff[crc_pkg::CRC_CTRL_WID_LO +: 2];

  assign data_ready_out = (state_ff == crc_pkg::CRC_ST_IDLE);
  assign data_wr = wr_in && (addr_in == crc_pkg::CRC_OFF_DATA) && data_ready_out;
  // A start write aborts a word still in the engine
  assign start_wr = wr_in && (addr_in == crc_pkg::CRC_OFF_CTRL) &&
    wdata_in[crc_pkg::CRC_CTRL_START];

  // ****************************************
  // Input shaping
  // ****************************************
  // optional input complement
  always_comb begin
    din = ctrl_ff[crc_pkg::CRC_CTRL_DINV] ? ~wdata_in : wdata_in;
    for (int b = 0; b < 32; b++) begin
      din_rev[b] = din[(b & ~7) + (7 - (b & 7))];
    end
    if (ctrl_ff[crc_pkg::CRC_CTRL_DREV]) begin
      din = din_rev;
    end
  end

  // One engine byte per cycle: 1, 2 or 4 cycles per write
  // byte in one cycle
  assign step_byte = (state_ff == crc_pkg::CRC_ST_IDLE) ? din[7:0] : shreg_ff[7:0];

  crc_byte_step u_step (
    .crc_in(crc_ff),
    .byte_in(step_byte),
    .sel_in(sel),
    .crc_out(step_out)
  );

  // ****************************************
  // Result shaping
  // ****************************************
  always_comb begin
    case (sel)
      crc_pkg::CRC_SEL_8: width_mask = 32'h0000_00FF;
      crc_pkg::CRC_SEL_32: width_mask = 32'hFFFF_FFFF;
      default: width_mask = 32'h0000_FFFF;
    endcase
    sum_masked = crc_ff & width_mask;
    sum_rev = 32'h0000_0000;
    for (int b = 0; b < 32; b++) begin
      sum_rev[b] = crc_ff[31 - b];
    end
    case (sel)
      crc_pkg::CRC_SEL_8: sum_rev = sum_rev >> 24;
      crc_pkg::CRC_SEL_32: sum_rev = sum_rev;
      default: sum_rev = sum_rev >> 16;
    endcase
    sum_view = ctrl_ff[crc_pkg::CRC_CTRL_SREV] ? sum_rev : sum_masked;
    if (ctrl_ff[crc_pkg::CRC_CTRL_SINV]) begin
      sum_view = ~sum_view & width_mask;
    end
  end

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_seed = seed_ff;
    nxt_crc = crc_ff;
    nxt_shreg = shreg_ff;
    nxt_left = left_ff;
    nxt_state = state_ff;
    nxt_rdata = 32'h0000_0000;
    // Start is self-clearing so it reads back as zero
    nxt_ctrl[crc_pkg::CRC_CTRL_START] = 1'b0;
    if (wr_in && (addr_in == crc_pkg::CRC_OFF_CTRL)) begin
      nxt_ctrl = wdata_in & 32'h0000_331F;
      nxt_ctrl[crc_pkg::CRC_CTRL_START] = 1'b0;
      if (wdata_in[crc_pkg::CRC_CTRL_START]) begin
        nxt_crc = seed_ff & 32'hFFFF_FFFF;
        nxt_state = crc_pkg::CRC_ST_IDLE;
        nxt_left = 2'h0;
      end
    end else if (wr_in && (addr_in == crc_pkg::CRC_OFF_SEED)) begin
      nxt_seed = wdata_in;
    end
    if (data_wr) begin
      nxt_crc = step_out;
      nxt_shreg = din >> 8;
      case (wid)
        crc_pkg::CRC_WID_8: nxt_left = 2'h0;
        crc_pkg::CRC_WID_16: nxt_left = crc_pkg::CRC_LEFT_16;
        default: nxt_left = crc_pkg::CRC_LEFT_32;
      endcase
      if (wid != crc_pkg::CRC_WID_8) begin
        nxt_state = crc_pkg::CRC_ST_RUN;
      end
    end else if ((state_ff == crc_pkg::CRC_ST_RUN) && !start_wr) begin
      nxt_crc = step_out;
      nxt_shreg = shreg_ff >> 8;
      nxt_left = left_ff - 2'h1;
      if (left_ff == 2'h1) begin
        nxt_state = crc_pkg::CRC_ST_IDLE;
      end
    end
    // Read data valid one cycle after the strobe
    if (rd_in) begin
      if (addr_in == crc_pkg::CRC_OFF_CTRL) begin
        nxt_rdata = ctrl_ff;
        nxt_rdata[crc_pkg::CRC_CTRL_BUSY] = (state_ff != crc_pkg::CRC_ST_IDLE);
      end else if (addr_in == crc_pkg::CRC_OFF_SEED) begin
        nxt_rdata = seed_ff;
      end else if (addr_in == crc_pkg::CRC_OFF_SUM) begin
        nxt_rdata = sum_view;
      end else begin
        nxt_rdata = 32'h0000_0000;
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctrl_ff <= crc_pkg::CRC_CTRL_RST;
      seed_ff <= crc_pkg::CRC_SEED_RST;
      crc_ff <= crc_pkg::CRC_SEED_RST;
      shreg_ff <= 32'h0000_0000;
      left_ff <= 2'h0;
      state_ff <= crc_pkg::CRC_ST_IDLE;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      seed_ff <= nxt_seed;
      crc_ff <= nxt_crc;
      shreg_ff <= nxt_shreg;
      left_ff <= nxt_left;
      state_ff <= nxt_state;
      rdata_ff <= nxt_rdata;
    end
  end

  assign rdata_out = rdata_ff;

endmodule // crc_gen
`default_nettype wire

/* File: testbench/crc_gen_monitor.sv */
// Port timing checker for the checksum generator.
// Assumes it is bound to crc_gen and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module crc_gen_monitor (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic data_ready_out
);
  logic [1:0] wid_ff;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Width tracks the last control write
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) wid_ff <= 2'h0;
    else if (wr_in && addr_in == crc_pkg::CRC_OFF_CTRL) wid_ff <= wdata_in[9:8];
  end
  sequence s_data_wr;
    wr_in && addr_in == crc_pkg::CRC_OFF_DATA && data_ready_out;
  endsequence
  sequence s_ctrl_rd;
    rd_in && addr_in == crc_pkg::CRC_OFF_CTRL;
  endsequence
  a_byte_one_cycle: assert property (s_data_wr ##0 wid_ff == 2'h0 |=> data_ready_out)
    else $error("byte write stalled");
  a_half_two_cycles: assert property (s_data_wr ##0 wid_ff == 2'h1 |=> !data_ready_out ##1
    data_ready_out) else $error("halfword timing wrong");
  a_word_four_cycles: assert property (s_data_wr ##0 wid_ff[1] |=> !data_ready_out [*3] ##1
    data_ready_out) else $error("word timing wrong");
  a_ready_fall_cause: assert property ($fell(data_ready_out) |-> $past(wr_in) &&
    $past(addr_in) == crc_pkg::CRC_OFF_DATA) else $error("stall without data write");
  a_idle_stays_ready: assert property (data_ready_out && !(wr_in && addr_in ==
    crc_pkg::CRC_OFF_DATA) |=> data_ready_out) else $error("ready dropped");
  a_rdata_quiet: assert property (!rd_in |=> rdata_out == 32'h0)
    else $error("read data outside window");
  a_ctrl_read_flags: assert property (s_ctrl_rd |=> !rdata_out[crc_pkg::CRC_CTRL_START] &&
    rdata_out[crc_pkg::CRC_CTRL_BUSY] == !$past(data_ready_out)) else $error("ctrl flags wrong");
  a_unmapped_zero: assert property (rd_in && addr_in[1:0] != 2'h0 |=> rdata_out == 32'h0)
    else $error("unmapped read not zero");
endmodule // crc_gen_monitor
bind crc_gen crc_gen_monitor u_mon (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
  .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
  .rdata_out(rdata_out), .data_ready_out(data_ready_out));
`default_nettype wire

/* File: testbench/crc_bus_master.sv */
// Bus master model: processor register access and a DMA data feeder.
// Assumes the strobe port of crc_gen with read data one cycle later.
`timescale 1ns/1ps
`default_nettype none
module crc_bus_master (
  // Clock and answers
  input wire logic ref_clk_in,
  input wire logic ready_in,
  input wire logic [31:0] rdata_in,
  // Requests
  output var logic [3:0] addr_out,
  output var logic [31:0] wdata_out,
  output var logic wr_out,
  output var logic rd_out
);
  initial begin
    addr_out = 4'h0;
    wdata_out = 32'h0;
    wr_out = 1'b0;
    rd_out = 1'b0;
  end
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    wdata_out <= d;
    wr_out <= 1'b1;
    @(posedge ref_clk_in);
    wr_out <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr_out <= a;
    rd_out <= 1'b1;
    @(posedge ref_clk_in);
    rd_out <= 1'b0;
    @(negedge ref_clk_in);
    d = rdata_in;
  endtask
  // Bounded wait; returns after at most nine falling edges even if ready stays low
  task automatic wait_ready();
    // Step off the edge, or a stall launched there is not yet visible
    @(negedge ref_clk_in);
    for (int i = 0; i < 8 && ready_in !== 1'b1; i++) @(negedge ref_clk_in);
  endtask
  task automatic dma_wr(input logic [31:0] d);
    wait_ready();
    wr_reg(crc_pkg::CRC_OFF_DATA, d);
  endtask
endmodule // crc_bus_master
`default_nettype wire

/* File: testbench/tb.sv */
// Self-checking bench for crc_gen against an integer checksum model.
// Assumes a 50 MHz clock and the bus master model in crc_bus_master.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk, arst_n, wr, rd, ready;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  int miscompares = 0, tests_run = 0, cyc = 0;
  crc_gen dut (.ref_clk_in(clk), .arst_n_in(arst_n), .addr_in(addr), .wdata_in(wdata),
    .wr_in(wr), .rd_in(rd), .rdata_out(rdata), .data_ready_out(ready));
  crc_bus_master bus (.ref_clk_in(clk), .ready_in(ready), .rdata_in(rdata),
    .addr_out(addr), .wdata_out(wdata), .wr_out(wr), .rd_out(rd));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Run takes a few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  function automatic logic [31:0] msk(input int w);
    return (w == 32) ? 32'hFFFFFFFF : ((32'h1 << w) - 32'h1);
  endfunction
  // Bytes low first, each MSB first
  function automatic logic [31:0] fold(input logic [31:0] a, input logic [31:0] d, input int nb,
    input int w, input logic [31:0] p, input logic rv, input logic iv);
    logic [7:0] b, br;
    for (int i = 0; i < nb; i++) begin
      b = d[8*i+:8];
      br = {<<{b}};
      if (rv) b = br;
      if (iv) b = ~b;
      a = a ^ (32'(b) << (w - 8));
      for (int k = 0; k < 8; k++) a = a[w-1] ? ((a << 1) ^ p) : (a << 1);
      a = a & msk(w);
    end
    return a;
  endfunction
  initial begin
    int sel, wid, w, nb, nw;
    logic [3:0] fl;
    logic [31:0] p, seed, acc, d, r, rv, got, ctl;
    arst_n = 1'b0;
    void'($urandom(32'h25AC8394));
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    bus.rd_reg(crc_pkg::CRC_OFF_SEED, got);
    chk("seed_rst", crc_pkg::CRC_SEED_RST, got);
    bus.rd_reg(crc_pkg::CRC_OFF_CTRL, got);
    chk("ctrl_rst", crc_pkg::CRC_CTRL_RST, got);
    for (int run = 0; run < 12; run++) begin
      sel = run % 4;
      wid = run / 4;
      fl = 4'($urandom);
      seed = $urandom;
      nw = 1 + $urandom % 4;
      w = (sel == 1) ? 8 : (sel == 3) ? 32 : 16;
      p = (sel == 0) ? crc_pkg::CRC_POLY_CCITT : (sel == 1) ? crc_pkg::CRC_POLY_8 :
        (sel == 2) ? crc_pkg::CRC_POLY_16 : crc_pkg::CRC_POLY_32;
      nb = (wid == 0) ? 1 : (wid == 1) ? 2 : 4;
      ctl = (32'(sel) << 12) | (32'(wid) << 8) | (32'(fl) << 1);
      bus.wr_reg(crc_pkg::CRC_OFF_SEED, seed);
      bus.rd_reg(crc_pkg::CRC_OFF_SEED, got);
      chk("seed", seed, got);
      bus.wr_reg(crc_pkg::CRC_OFF_CTRL, ctl | 32'h1);
      acc = seed & msk(w);
      for (int i = 0; i < nw; i++) begin
        d = $urandom;
        if (run % 2 == 1) bus.dma_wr(d);
        else bus.wr_reg(crc_pkg::CRC_OFF_DATA, d);
        // Undelayed 32-bit words every other cycle lose each second word
        if (run % 2 == 1 || nb < 4 || i % 2 == 0) acc = fold(acc, d, nb, w, p, fl[0], fl[2]);
      end
      bus.wait_ready();
      rv = {<<{acc}};
      r = fl[1] ? (rv >> (32 - w)) : acc;
      if (fl[3]) r = r ^ msk(w);
      bus.rd_reg(crc_pkg::CRC_OFF_SUM, got);
      chk("sum", r, got);
      bus.rd_reg(crc_pkg::CRC_OFF_CTRL, got);
      chk("ctrl", ctl, got & 32'h0000331E);
      bus.rd_reg(4'(1 + run % 3), got);
      chk("unmapped", 32'h0, got);
    end
    give_verdict();
  end
endmodule // tb
`default_nettype wire
